// >>> spi_cmd_device.sv
// Purpose: Device end of the serial command link; decodes instructions.
// Assumes: Link pins are asynchronous to clk_sys and are synchronised here.
// Notes:   Register and buffer storage sit outside, on the user-side ports.
// Operation
// - Serial link works in clock mode 0,0 only.
// - Host keeps serial clock low while idle.
// - Input bits sampled on serial clock rise.
// - Output bit changes on serial clock fall.
// - Chip select low frames the whole operation.
// - First byte: 3-bit opcode, 5-bit argument.
// - Write-type instructions carry data bytes after.
// - Seven opcodes decoded; buffer commands need 1Ah.
// - Soft reset is the single byte FFh.
// - Read argument is a 5-bit register address.
// - Core register data shifts out immediately, MSB-first.
// - MAC/MII reads send one dummy byte first.
// - Read ends and output released at deselect.
// - No direct path to PHY registers.
// - Write lands on eighth bit; partial byte dropped.
// - Set-bits ORs into core registers only.
// - Clear-bits ANDs inverted data on last bit.
// - Buffer read streams bytes, advancing pointer each.
`timescale 1ns/100ps
module spi_cmd_device
    import spi_cmd_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    spi_cmd_if.dev                  link,
    output spi_cmd_pkg::arg_t       reg_addr,
    input  wire spi_cmd_pkg::byte_t reg_rd_data,
    input  wire logic               reg_is_mac_mii,
    output logic                    reg_wr_en,
    output spi_cmd_pkg::byte_t      reg_wr_data,
    input  wire spi_cmd_pkg::byte_t buf_rd_data,
    output logic                    buf_rd_next,
    output logic                    buf_wr_en,
    output spi_cmd_pkg::byte_t      buf_wr_data,
    output logic                    soft_reset
);
    import spi_cmd_pkg::*;

    logic       sck_s1;
    logic       sck_s2;
    logic       sck_s3;
    logic       cs_s1;
    logic       cs_s2;
    logic       si_s1;
    logic       si_s2;
    logic       sck_rise;
    logic       sck_fall;
    logic       byte_done;
    byte_t      byte_in;
    logic [2:0] bit_cnt_reg;
    byte_t      in_sr_reg;
    dev_state_t state_reg;
    dev_state_t cmd_next;
    opc_t       op_reg;
    logic       load_req_reg;
    logic       first_reg;
    byte_t      tx_sr_reg;
    logic       so_reg;

    function automatic logic buf_arg_ok(input byte_t b);
        buf_arg_ok = (b[ARG_MSB:ARG_LSB] == BUF_ARG);
    endfunction

    function automatic dev_state_t decode_cmd(input byte_t b);
        case (b[OPC_MSB:OPC_LSB])
            OP_REG_READ:  decode_cmd = ST_READ;
            OP_BUF_READ:  decode_cmd = buf_arg_ok(b) ? ST_READ : ST_IGNORE;
            OP_REG_WRITE: decode_cmd = ST_WRITE;
            OP_BUF_WRITE: decode_cmd = buf_arg_ok(b) ? ST_WRITE : ST_IGNORE;
            OP_SET_BITS:  decode_cmd = ST_WRITE;
            OP_CLR_BITS:  decode_cmd = ST_WRITE;
            default:      decode_cmd = ST_IGNORE;
        endcase
    endfunction

    // Two flip-flops on every pin, one more on the clock to find its edges.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            si_s1  <= 1'b0;
            si_s2  <= 1'b0;
        end
        else
        begin
            sck_s1 <= link.sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            cs_s1  <= link.cs_n;
            cs_s2  <= cs_s1;
            si_s1  <= link.si;
            si_s2  <= si_s1;
        end
    end

    // Only mode 0,0 edges count, and only inside a frame.
    assign sck_rise  = sck_s2 & ~sck_s3 & ~cs_s2;
    assign sck_fall  = ~sck_s2 & sck_s3 & ~cs_s2;
    assign byte_in   = {in_sr_reg[6:0], si_s2};
    assign byte_done = sck_rise && (bit_cnt_reg == 3'(LAST_BIT));
    assign cmd_next  = decode_cmd(byte_in);

    // Bit counter and input shifter; deselect drops any partial byte.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_reg <= 3'h0;
            in_sr_reg   <= 8'h00;
        end
        else if (cs_s2)
        begin
            bit_cnt_reg <= 3'h0;
        end
        else if (sck_rise)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            in_sr_reg   <= byte_in;
        end
    end

    // Instruction decode.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_CMD;
            op_reg    <= OP_REG_READ;
            reg_addr  <= 5'h00;
        end
        else if (cs_s2)
        begin
            state_reg <= ST_CMD;
        end
        else if (byte_done && state_reg == ST_CMD)
        begin
            op_reg    <= byte_in[OPC_MSB:OPC_LSB];
            reg_addr  <= byte_in[ARG_MSB:ARG_LSB];
            state_reg <= cmd_next;
        end
    end

    // Reload the output shifter once per byte of a read.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_req_reg <= 1'b0;
            first_reg    <= 1'b0;
            buf_rd_next  <= 1'b0;
        end
        else
        begin
            load_req_reg <= 1'b0;
            buf_rd_next  <= 1'b0;
            if (byte_done && state_reg == ST_CMD && cmd_next == ST_READ)
            begin
                load_req_reg <= 1'b1;
                first_reg    <= 1'b1;
            end
            else if (byte_done && state_reg == ST_READ)
            begin
                load_req_reg <= (op_reg != OP_BUF_READ);
                buf_rd_next  <= (op_reg == OP_BUF_READ);
            end
            if (buf_rd_next)
                load_req_reg <= 1'b1;
            if (load_req_reg)
            begin
                first_reg <= 1'b0;
            end
        end
    end

    // Output shifter reloads on load_req_reg and shifts only on the falling serial clock.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_sr_reg <= 8'h00;
            so_reg    <= 1'b0;
        end
        else if (load_req_reg)
        begin
            if (op_reg == OP_BUF_READ)
            begin
                tx_sr_reg <= buf_rd_data;
            end
            else if (first_reg && reg_is_mac_mii)
            begin
                tx_sr_reg <= DUMMY_BYTE;
            end
            else
            begin
                tx_sr_reg <= reg_rd_data;
            end
        end
        else if (sck_fall && state_reg == ST_READ)
        begin
            so_reg    <= tx_sr_reg[7];
            tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
        end
    end

    assign link.so_drv = so_reg;
    assign link.so_oe  = (state_reg == ST_READ);

    // Write-type effects on the eighth data bit.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_wr_en   <= 1'b0;
            reg_wr_data <= 8'h00;
            buf_wr_en   <= 1'b0;
            buf_wr_data <= 8'h00;
            soft_reset  <= 1'b0;
        end
        else
        begin
            reg_wr_en  <= 1'b0;
            buf_wr_en  <= 1'b0;
            soft_reset <= 1'b0;
            if (byte_done && state_reg == ST_CMD && byte_in == SOFT_RESET_BYTE)
            begin
                soft_reset <= 1'b1;
            end
            if (byte_done && state_reg == ST_WRITE)
            begin
                case (op_reg)
                    OP_REG_WRITE:
                    begin
                        reg_wr_en   <= 1'b1;
                        reg_wr_data <= byte_in;
                    end
                    OP_SET_BITS:
                    begin
                        reg_wr_en   <= ~reg_is_mac_mii;
                        reg_wr_data <= reg_rd_data | byte_in;
                    end
                    OP_CLR_BITS:
                    begin
                        reg_wr_en   <= ~reg_is_mac_mii;
                        reg_wr_data <= reg_rd_data & ~byte_in;
                    end
                    OP_BUF_WRITE:
                    begin
                        buf_wr_en   <= 1'b1;
                        buf_wr_data <= byte_in;
                    end
                    default:
                    begin
                        reg_wr_en <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// >>> spi_cmd_host.sv
// Purpose: Host end of the serial command link; frames and clocks operations.
// Assumes: The serial clock is made here by dividing clk_sys.
// Notes:   cmd_len counts bytes clocked after the instruction byte.
`timescale 1ns/100ps
module spi_cmd_host
    import spi_cmd_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    spi_cmd_if.host                 link,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire spi_cmd_pkg::opc_t  cmd_opcode,
    input  wire spi_cmd_pkg::arg_t  cmd_arg,
    input  wire spi_cmd_pkg::byte_t cmd_len,
    input  wire spi_cmd_pkg::byte_t tx_data,
    output logic                    tx_take,
    output spi_cmd_pkg::byte_t      rx_data,
    output logic                    rx_valid,
    output logic                    done
);
    import spi_cmd_pkg::*;

    host_state_t state_reg;
    logic [3:0]  div_reg;
    logic        tick;
    logic        sck_reg;
    logic        cs_n_reg;
    byte_t       sr_reg;
    byte_t       rx_sr_reg;
    logic [2:0]  bit_cnt_reg;
    byte_t       left_reg;
    logic        first_reg;
    logic        is_read_reg;
    logic        so_s1;
    logic        so_s2;
    logic        is_soft;

    assign tick      = (div_reg == 4'(SCK_HALF_CYCLES - 1));
    assign cmd_ready = (state_reg == H_IDLE);
    assign is_soft   = (cmd_opcode == OP_SOFT_RST);

    assign link.sck  = sck_reg;
    assign link.cs_n = cs_n_reg;
    assign link.si   = sr_reg[7];

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            so_s1 <= 1'b1;
            so_s2 <= 1'b1;
        end
        else
        begin
            so_s1 <= link.so_line;
            so_s2 <= so_s1;
        end
    end

    // Half-period divider for the serial clock.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= 4'h0;
        end
        else if (state_reg == H_IDLE || tick)
        begin
            div_reg <= 4'h0;
        end
        else
        begin
            div_reg <= div_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg   <= H_IDLE;
            sck_reg     <= 1'b0;
            cs_n_reg    <= 1'b1;
            sr_reg      <= 8'h00;
            rx_sr_reg   <= 8'h00;
            rx_data     <= 8'h00;
            bit_cnt_reg <= 3'h0;
            left_reg    <= 8'h00;
            first_reg   <= 1'b0;
            is_read_reg <= 1'b0;
            tx_take     <= 1'b0;
            rx_valid    <= 1'b0;
            done        <= 1'b0;
        end
        else
        begin
            tx_take  <= 1'b0;
            rx_valid <= 1'b0;
            done     <= 1'b0;
            case (state_reg)
                H_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        cs_n_reg    <= 1'b0;
                        sr_reg      <= {cmd_opcode, is_soft ? SOFT_RST_ARG : cmd_arg};
                        left_reg    <= is_soft ? 8'h00 : cmd_len;
                        is_read_reg <= (cmd_opcode == OP_REG_READ) ||
                                       (cmd_opcode == OP_BUF_READ);
                        first_reg   <= 1'b1;
                        bit_cnt_reg <= 3'h0;
                        state_reg   <= H_SETUP;
                    end
                end
                H_SETUP:
                begin
                    if (tick)
                    begin
                        state_reg <= H_LOW;
                    end
                end
                H_LOW:
                begin
                    if (tick)
                    begin
                        sck_reg   <= 1'b1;
                        rx_sr_reg <= {rx_sr_reg[6:0], so_s2};
                        state_reg <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (tick)
                    begin
                        sck_reg     <= 1'b0;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        state_reg   <= H_LOW;
                        sr_reg      <= {sr_reg[6:0], 1'b0};
                        if (bit_cnt_reg == 3'(LAST_BIT))
                        begin
                            first_reg <= 1'b0;
                            if (!first_reg && is_read_reg)
                            begin
                                rx_valid <= 1'b1;
                                rx_data  <= rx_sr_reg;
                            end
                            if (left_reg == 8'h00)
                            begin
                                state_reg <= H_HOLD;
                            end
                            else
                            begin
                                left_reg <= left_reg - 8'h01;
                                sr_reg   <= is_read_reg ? READ_FILL_BYTE : tx_data;
                                tx_take  <= ~is_read_reg;
                            end
                        end
                    end
                end
                H_HOLD:
                begin
                    if (tick)
                    begin
                        cs_n_reg  <= 1'b1;
                        done      <= 1'b1;
                        state_reg <= H_GAP;
                    end
                end
                H_GAP:
                begin
                    if (tick)
                    begin
                        state_reg <= H_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

endmodule

// >>> spi_cmd_if.sv
// Purpose: Pins of the serial command link between host and device.
// Assumes: The device drives the serial output only while so_oe is high.
// Notes:   An undriven serial output line reads high.
`timescale 1ns/100ps
interface spi_cmd_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so_drv;
    logic so_oe;
    logic so_line;

    assign so_line = so_oe ? so_drv : 1'b1;

    modport dev
    (
        input  sck,
        input  cs_n,
        input  si,
        output so_drv,
        output so_oe
    );

    modport host
    (
        output sck,
        output cs_n,
        output si,
        input  so_line
    );
endinterface

// >>> spi_cmd_pkg.sv
// Purpose: Shared constants and types for the serial command link.
// Assumes: Both ends run clk_sys at 40 MHz.
// Notes:   Instruction byte is opcode in bits 7:5, argument in bits 4:0.
package spi_cmd_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [4:0] arg_t;
    typedef logic [2:0] opc_t;

    localparam opc_t OP_REG_READ  = 3'h0;
    localparam opc_t OP_BUF_READ  = 3'h1;
    localparam opc_t OP_REG_WRITE = 3'h2;
    localparam opc_t OP_BUF_WRITE = 3'h3;
    localparam opc_t OP_SET_BITS  = 3'h4;
    localparam opc_t OP_CLR_BITS  = 3'h5;
    localparam opc_t OP_SOFT_RST  = 3'h7;

    localparam arg_t  BUF_ARG         = 5'h1a;
    localparam arg_t  SOFT_RST_ARG    = 5'h1f;
    localparam byte_t SOFT_RESET_BYTE = 8'hff;
    localparam byte_t DUMMY_BYTE      = 8'h00;
    localparam byte_t READ_FILL_BYTE  = 8'h00;

    localparam int OPC_MSB  = 7;
    localparam int OPC_LSB  = 5;
    localparam int ARG_MSB  = 4;
    localparam int ARG_LSB  = 0;
    localparam int LAST_BIT = 7;

    localparam int CLK_PERIOD_NS   = 25;
    localparam int SCK_HALF_NS     = 200;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_CMD, ST_READ, ST_WRITE, ST_IGNORE} dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} host_state_t;

endpackage

// >>> spi_command_interface_assertions.sv
// Purpose: Protocol checks on the wires of the serial command link.
// Assumes: Both link ends are design modules that share clk_sys.
// Notes:   Inputs mirror the interface signals one for one.
`timescale 1ns/100ps
module spi_command_interface_assertions
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_drv,
    input wire logic so_oe,
    input wire logic so_line
);
    logic [3:0] rise_cnt_reg;
    logic       sck_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Counts serial clock rises inside a frame, wrapping at sixteen.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sck_reg      <= 1'b0;
            rise_cnt_reg <= 4'h0;
        end
        else
        begin
            sck_reg <= sck;
            if (cs_n)
                rise_cnt_reg <= 4'h0;
            else if (sck && !sck_reg)
                rise_cnt_reg <= rise_cnt_reg + 4'h1;
        end
    end

    sequence s_high_phase;
        sck [*8] ##1 !sck;
    endsequence

    sequence s_low_setup;
        (!sck) [*8];
    endsequence

    property p_sck_idle_low;   cs_n |-> !sck; endproperty
    property p_half_period;    $rose(sck) |-> s_high_phase; endproperty
    property p_cs_setup;       $fell(cs_n) |-> s_low_setup; endproperty
    property p_cs_hold;        $rose(cs_n) |-> !$past(sck, 1) && !$past(sck, 7); endproperty
    property p_si_stable;      (sck && !cs_n) |-> $stable(si); endproperty
    property p_so_on_fall;
        (so_oe && $past(so_oe) && $changed(so_drv)) |-> !sck && !$past(sck, 2);
    endproperty
    property p_oe_release;     cs_n [*5] |-> !so_oe && so_line; endproperty
    property p_oe_after_instr; $rose(so_oe) |-> !cs_n && rise_cnt_reg == 4'h8; endproperty
    property p_whole_bytes;    $rose(cs_n) |-> rise_cnt_reg[2:0] == 3'h0; endproperty

    a_sck_idle_low: assert property (p_sck_idle_low)
        else $error("Serial clock high while deselected.");
    a_half_period: assert property (p_half_period)
        else $error("Serial clock high phase has the wrong length.");
    a_cs_setup: assert property (p_cs_setup)
        else $error("Serial clock rose too soon after select.");
    a_cs_hold: assert property (p_cs_hold)
        else $error("Deselect came too soon after the last clock.");
    a_si_stable: assert property (p_si_stable)
        else $error("Serial input changed while the clock was high.");
    a_so_on_fall: assert property (p_so_on_fall)
        else $error("Serial output changed away from a falling clock.");
    a_oe_release: assert property (p_oe_release)
        else $error("Serial output still driven after deselect.");
    a_oe_after_instr: assert property (p_oe_after_instr)
        else $error("Serial output driven before the instruction byte ended.");
    a_whole_bytes: assert property (p_whole_bytes)
        else $error("Frame did not hold whole bytes.");
endmodule

// >>> spi_command_interface_tb.sv
// Purpose: Self-checking bench joining host and device ends of the link.
// Assumes: Register and buffer storage are modelled here on the device side.
// Notes:   A second device is driven bit by bit to test aborted frames.
`timescale 1ns/100ps
module spi_command_interface_tb;
    import spi_cmd_pkg::*;

    logic       clk_sys;
    logic       rst_n;
    logic       cmd_valid;
    logic       cmd_ready;
    opc_t       cmd_opcode;
    arg_t       cmd_arg;
    byte_t      cmd_len;
    logic       tx_take;
    byte_t      rx_data;
    logic       rx_valid;
    logic       done;
    arg_t       reg_addr;
    logic       reg_wr_en;
    byte_t      reg_wr_data;
    logic       buf_rd_next;
    logic       buf_wr_en;
    byte_t      buf_wr_data;
    logic       soft_reset;
    logic       reg_wr_en2;
    byte_t      reg_wr_data2;
    byte_t      w2_data;
    byte_t      regs [32];
    byte_t      exp_regs [32];
    byte_t      bufm [16];
    byte_t      tx_buf [8];
    logic [3:0] rd_ptr;
    logic [3:0] wr_ptr;
    logic [2:0] tx_idx;
    byte_t      exp_q [$];
    int         errors;
    int         total_checks;
    int         wr_cnt;
    int         bw_cnt;
    int         sr_cnt;
    int         w2_cnt;

    spi_cmd_if link();
    spi_cmd_if link2();

    spi_cmd_host spi_cmd_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
        .cmd_arg(cmd_arg), .cmd_len(cmd_len), .tx_data(tx_buf[tx_idx]), .tx_take(tx_take),
        .rx_data(rx_data), .rx_valid(rx_valid), .done(done));

    spi_cmd_device spi_cmd_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .reg_addr(reg_addr), .reg_rd_data(regs[reg_addr]), .reg_is_mac_mii(reg_addr[4]),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .buf_rd_data(bufm[rd_ptr]),
        .buf_rd_next(buf_rd_next), .buf_wr_en(buf_wr_en), .buf_wr_data(buf_wr_data),
        .soft_reset(soft_reset));

    spi_cmd_device spi_cmd_device_i2 (.clk_sys(clk_sys), .rst_n(rst_n), .link(link2),
        .reg_addr(), .reg_rd_data(8'h00), .reg_is_mac_mii(1'b0), .reg_wr_en(reg_wr_en2),
        .reg_wr_data(reg_wr_data2), .buf_rd_data(8'h00), .buf_rd_next(), .buf_wr_en(),
        .buf_wr_data(), .soft_reset());

    spi_command_interface_assertions spi_command_interface_assertions_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so_drv(link.so_drv),
        .so_oe(link.so_oe), .so_line(link.so_line));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Device-side storage and event counters.
    always @(posedge clk_sys)
    begin
        if (reg_wr_en === 1'b1)
        begin
            regs[reg_addr] <= reg_wr_data;
            wr_cnt <= wr_cnt + 1;
        end
        if (buf_wr_en === 1'b1)
        begin
            bufm[wr_ptr] <= buf_wr_data;
            wr_ptr <= wr_ptr + 4'h1;
            bw_cnt <= bw_cnt + 1;
        end
        if (buf_rd_next === 1'b1)
            rd_ptr <= rd_ptr + 4'h1;
        if (tx_take === 1'b1)
            tx_idx <= tx_idx + 3'h1;
        if (soft_reset === 1'b1)
            sr_cnt <= sr_cnt + 1;
        if (reg_wr_en2 === 1'b1)
        begin
            w2_cnt <= w2_cnt + 1;
            w2_data <= reg_wr_data2;
        end
    end

    task automatic test_done;
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic wait_for(input int limit, input string msg);
        int n;
        for (n = 0; n < limit && (cmd_ready !== 1'b1 || done !== 1'b0); n++)
            @(negedge clk_sys);
        if (n == limit)
        begin
            chk(1'b0, msg);
            test_done();
        end
    endtask

    task automatic run(input opc_t op, input arg_t arg, input byte_t len);
        int n;
        @(negedge clk_sys);
        wait_for(100, "host not ready");
        tx_idx     = 3'h0;
        cmd_opcode = op;
        cmd_arg    = arg;
        cmd_len    = len;
        cmd_valid  = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        for (n = 0; n < 4000 && done !== 1'b1; n++)
            @(negedge clk_sys);
        if (n == 4000)
        begin
            chk(1'b0, "frame timeout");
            test_done();
        end
    endtask

    // Notes the expected reply bytes of a register read, then runs it.
    task automatic rd(input arg_t a, input byte_t len);
        int k;
        for (k = 0; k < len; k++)
            exp_q.push_back((a[4] && k == 0) ? DUMMY_BYTE : exp_regs[a]);
        run(OP_REG_READ, a, len);
    endtask

    task automatic bang(input logic [15:0] w, input int nbits);
        int k;
        link2.cs_n = 1'b0;
        #(SCK_HALF_NS);
        for (k = 0; k < nbits; k++)
        begin
            link2.si = w[15 - k];
            #(SCK_HALF_NS);
            link2.sck = 1'b1;
            #(SCK_HALF_NS);
            link2.sck = 1'b0;
        end
        #(SCK_HALF_NS);
        link2.cs_n = 1'b1;
        link2.si   = ~link2.si;
        #(2 * SCK_HALF_NS);
    endtask

    always @(negedge clk_sys)
    begin
        if (rx_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1'b0, "unexpected read byte");
            else
                chk(rx_data === exp_q.pop_front(), "read byte mismatch");
        end
    end

    initial
    begin
        int    i;
        arg_t  a;
        byte_t d;
        int    c;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_opcode = OP_REG_READ;
        cmd_arg = 5'h00;
        cmd_len = 8'h00;
        {errors, total_checks, wr_cnt, bw_cnt, sr_cnt, w2_cnt} = '0;
        {rd_ptr, wr_ptr, tx_idx, w2_data} = '0;
        link2.sck = 1'b0;
        link2.cs_n = 1'b1;
        link2.si = 1'b0;
        void'($urandom(44));
        for (i = 0; i < 32; i++)
        begin
            exp_regs[i] = $urandom;
            regs[i] = exp_regs[i];
        end
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            a = (i < 2) ? 5'h03 + i : 5'h12 + i;
            tx_buf[0] = $urandom;
            exp_regs[a] = tx_buf[0];
            run(OP_REG_WRITE, a, 8'h01);
            rd(a, 8'h02);
        end
        for (i = 0; i < 2; i++)
        begin
            a = i ? 5'h14 : 5'h05;
            d = $urandom;
            tx_buf[0] = d;
            run(OP_SET_BITS, a, 8'h01);
            exp_regs[a] = a[4] ? exp_regs[a] : exp_regs[a] | d;
            rd(a, 8'h02);
            d = $urandom;
            tx_buf[0] = d;
            run(OP_CLR_BITS, a, 8'h01);
            exp_regs[a] = a[4] ? exp_regs[a] : exp_regs[a] & ~d;
            rd(a, 8'h02);
        end
        c = wr_cnt;
        tx_buf[0] = $urandom;
        tx_buf[1] = $urandom;
        exp_regs[6] = tx_buf[1];
        run(OP_REG_WRITE, 5'h06, 8'h02);
        chk(wr_cnt == c + 2, "write count for two bytes");
        rd(5'h06, 8'h01);
        for (i = 0; i < 3; i++)
            tx_buf[i] = $urandom;
        run(OP_BUF_WRITE, BUF_ARG, 8'h03);
        chk(bw_cnt == 3, "buffer write count");
        for (i = 0; i < 3; i++)
            exp_q.push_back(tx_buf[i]);
        run(OP_BUF_READ, BUF_ARG, 8'h03);
        chk(rd_ptr === 4'h3, "buffer read pointer");
        c = wr_cnt;
        run(3'h6, 5'h03, 8'h01);
        run(OP_BUF_WRITE, 5'h00, 8'h01);
        chk(wr_cnt == c && bw_cnt == 3 && sr_cnt == 0, "refused command acted");
        run(OP_SOFT_RST, 5'h00, 8'h05);
        chk(sr_cnt == 1, "soft reset count");
        d = $urandom;
        bang({OP_REG_WRITE, 5'h03, d}, 13);
        chk(w2_cnt == 0, "partial byte was written");
        bang({OP_REG_WRITE, 5'h03, d}, 16);
        chk(w2_cnt == 1 && w2_data === d, "write after abort");
        repeat (40) @(negedge clk_sys);
        chk(exp_q.size() == 0, "read bytes missing");
        test_done();
    end
endmodule
